// ---- logic/mmd_pkg.sv ----
// package for the memory map address decoder
package mmd_pkg;

  // region bounds
  localparam logic [15:0] IO_LO      = 16'h0000;
  localparam logic [15:0] IO_HI      = 16'h007F;
  localparam logic [15:0] XIO_LO     = 16'h0F80;
  localparam logic [15:0] XIO_HI     = 16'h0FFF;
  localparam logic [15:0] RAM_LO     = 16'h0090;
  localparam logic [15:0] RAM_HI_BIG = 16'h047F;
  localparam logic [15:0] RAM_HI_SML = 16'h028F;
  localparam logic [15:0] GPR_LO     = 16'h0100;
  localparam logic [15:0] GPR_HI     = 16'h01FF;
  localparam logic [15:0] NVR_LO     = 16'hFFBB;
  localparam logic [15:0] NVR_HI     = 16'hFFBF;
  localparam logic [15:0] VEC_LO     = 16'hFFC0;
  localparam logic [15:0] VEC_HI     = 16'hFFFF;
  localparam logic [15:0] FLASH_LO   = 16'h1000;
  localparam logic [15:0] DIR_BANK_LO = 16'h0080;
  localparam logic [15:0] BANK_STEP  = 16'h0080;
  localparam logic [15:0] BANK_BASE  = 16'h0080;
  localparam logic [2:0]  DBP_RESET  = 3'h0;

  // oscillation stabilization wait in machine cycles
  localparam int          OSC_WAIT_CYC = 256;
  localparam logic [8:0]  OSC_WAIT_LD  = 9'(OSC_WAIT_CYC - 1);

  // region select, one hot
  typedef struct packed {
    logic io;
    logic xio;
    logic ram;
    logic gpr;
    logic nonvolatile_register;
    logic vec;
    logic flash;
    logic none;
  } mmd_sel_type;

  // cpu access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        direct;
    logic        gpr_mode;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mmd_req_type;

endpackage : mmd_pkg

// ---- logic/mmd_osc_wait.sv ----
// oscillation stabilization wait counter
module mmd_osc_wait
  import mmd_pkg::*;
(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // wait trigger and status
  input  wire logic i_start,
  output logic      o_busy
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic       busy_q;
  logic       busy_d;

  // count down once started
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (i_start) begin
      cnt_d  = OSC_WAIT_LD;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == 9'h000) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 9'h001;
      end
    end
  end

  // registers; busy from reset models the power-on wait
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cnt_q  <= OSC_WAIT_LD;
      busy_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign o_busy = busy_q;

endmodule : mmd_osc_wait

// ---- logic/mmd_decoder.sv ----
// memory map address decoder top
// Operation
// RULE1 - decode 16-bit address into one 64 KiB space
// RULE2 - 0x0000-0x007F selects peripheral I/O, normal and direct access
// RULE3 - 0x0F80-0x0FFF selects extended I/O by normal access
// RULE4 - RAM 0x0090-0x00FF reachable directly without bank pointer
// RULE5 - large variant: RAM 0x0090-0x047F direct via bank pointer
// RULE6 - small variant: direct region ends at 0x028F
// RULE7 - 0x0100-0x01FF is register window and also plain RAM
// RULE8 - 0xFFC0-0xFFFF is vector table fetched on calls and resets
// RULE9 - 0xFFBB-0xFFBF holds non-volatile register data
// RULE10 - reset pin is reset I/O after power-on, two control bits
// RULE11 - external clock still needs stabilization wait on wake
// RULE12 - direct 0x00-0x7F fixed; 0x80-0xFF banked by 3-bit pointer
// RULE13 - exactly one select; unmapped reads zero, writes ignored
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter bit SMALL_RAM = 1'b0
)
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // cpu access
  input  wire mmd_req_type i_req,
  input  wire logic [2:0]  i_gpr_bank,
  output mmd_sel_type      o_sel,
  output logic [15:0]      o_phys_addr,
  output logic             o_wr_en,
  output logic             o_rd_zero,
  // bank pointer load
  input  wire logic        i_dbp_we,
  input  wire logic [2:0]  i_dbp_wdata,
  output logic [2:0]       o_direct_bank_pointer,
  // vector fetch
  input  wire logic        i_vector_call_instruction,
  input  wire logic        i_vec_irq,
  input  wire logic [4:0]  i_vec_num,
  output logic [15:0]      o_vec_addr,
  // shared reset pin
  input  wire logic        i_cfg_we,
  input  wire logic        i_reset_output_enable_bit,
  input  wire logic        i_reset_pin_function_select,
  input  wire logic        i_int_reset_req,
  input  wire logic        i_shared_reset_pin,
  input  wire logic        i_gpio_out,
  input  wire logic        i_gpio_oe,
  output logic             o_shared_reset_pin,
  output logic             o_shared_reset_pin_oe,
  output logic             o_pin_reset,
  output logic             o_gpio_in,
  // clock control
  input  wire logic        i_ext_clk_sel,
  input  wire logic        i_wake_stop,
  input  wire logic        i_wake_sub,
  output logic             o_osc_wait
);

  // decode a cpu address into a one-hot select
  function automatic mmd_sel_type dec_region(input logic [15:0] a,
                                             input logic sml);
    mmd_sel_type s;
    logic [15:0] ram_top;
    s = '0;
    ram_top = sml ? RAM_HI_SML : RAM_HI_BIG;
    if (a <= IO_HI) begin
      s.io = 1'b1;                          // RULE2
    end else if (a >= XIO_LO && a <= XIO_HI) begin
      s.xio = 1'b1;                         // RULE3
    end else if (a >= GPR_LO && a <= GPR_HI) begin
      s.gpr = 1'b1;                         // RULE7
    end else if (a >= RAM_LO && a <= ram_top) begin
      s.ram = 1'b1;                         // RULE4
    end else if (a >= VEC_LO) begin
      s.vec = 1'b1;                         // RULE8
    end else if (a >= NVR_LO && a <= NVR_HI) begin
      s.nonvolatile_register = 1'b1;                         // RULE9
    end else if (a >= FLASH_LO) begin
      s.flash = 1'b1;
    end else begin
      s.none = 1'b1;                        // RULE13
    end
    return s;
  endfunction : dec_region

  // bank pointer state
  logic [2:0] dbp_q;
  logic [2:0] dbp_d;

  always_comb begin
    dbp_d = i_dbp_we ? i_dbp_wdata : dbp_q;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      dbp_q <= DBP_RESET;                   // RULE12
    end else begin
      dbp_q <= dbp_d;
    end
  end

  assign o_direct_bank_pointer = dbp_q;

  // address translation for direct and register modes
  logic [15:0] eff_addr;
  always_comb begin
    eff_addr = i_req.addr;                  // RULE1
    if (i_req.gpr_mode) begin
      eff_addr = GPR_LO | {8'h00, i_gpr_bank, i_req.addr[4:0]}; // RULE7
    end else if (i_req.direct) begin
      if (i_req.addr[7:0] < DIR_BANK_LO[7:0]) begin
        eff_addr = {8'h00, i_req.addr[7:0]}; // RULE12
      end else if (dbp_q == DBP_RESET) begin
        eff_addr = {8'h00, i_req.addr[7:0]}; // RULE4
      end else begin
        eff_addr = BANK_BASE + 16'(dbp_q) * BANK_STEP
                   + {9'h000, i_req.addr[6:0]}; // RULE5
      end
    end
  end

  // registered decode outputs
  mmd_sel_type sel_q;
  mmd_sel_type sel_d;
  logic [15:0] pa_q;
  logic [15:0] pa_d;
  logic        we_q;
  logic        we_d;
  logic        rz_q;
  logic        rz_d;

  always_comb begin
    sel_d = '0;
    pa_d  = pa_q;
    we_d  = 1'b0;
    rz_d  = 1'b0;
    if (i_req.valid) begin
      sel_d = dec_region(eff_addr, SMALL_RAM); // RULE6
      pa_d  = eff_addr;
      // flash, vector and nvr areas are not written by plain stores
      we_d  = i_req.write && !sel_d.none && !sel_d.flash
              && !sel_d.vec && !sel_d.nonvolatile_register; // RULE13
      rz_d  = !i_req.write && sel_d.none; // RULE13
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sel_q <= '0;
      pa_q  <= 16'h0000;
      we_q  <= 1'b0;
      rz_q  <= 1'b0;
    end else begin
      sel_q <= sel_d;
      pa_q  <= pa_d;
      we_q  <= we_d;
      rz_q  <= rz_d;
    end
  end

  assign o_sel       = sel_q;
  assign o_phys_addr = pa_q;
  assign o_wr_en     = we_q;
  assign o_rd_zero   = rz_q;

  // vector entry address, two bytes per entry from the table top
  logic [15:0] vec_q;
  logic [15:0] vec_d;
  always_comb begin
    vec_d = vec_q;
    if (i_vector_call_instruction || i_vec_irq) begin
      vec_d = VEC_HI - {10'h000, i_vec_num, 1'b1}; // RULE8
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      vec_q <= VEC_HI - 16'h0001;           // reset entry
    end else begin
      vec_q <= vec_d;
    end
  end

  assign o_vec_addr = vec_q;

  // pin input synchroniser
  logic pin_s1_q;
  logic pin_s2_q;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= i_shared_reset_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // pin function control; power-on: reset input with output enabled
  logic rst_oe_q;
  logic rst_oe_d;
  logic rst_en_q;
  logic rst_en_d;
  always_comb begin
    rst_oe_d = rst_oe_q;
    rst_en_d = rst_en_q;
    if (i_cfg_we) begin
      rst_oe_d = i_reset_output_enable_bit;   // RULE10
      rst_en_d = i_reset_pin_function_select; // RULE10
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rst_oe_q <= 1'b1;
      rst_en_q <= 1'b1;
    end else begin
      rst_oe_q <= rst_oe_d;
      rst_en_q <= rst_en_d;
    end
  end

  // pin drive: open-drain low for reset, else gpio when selected
  always_comb begin
    o_shared_reset_pin    = 1'b0;
    o_shared_reset_pin_oe = 1'b0;
    if (rst_en_q) begin
      o_shared_reset_pin_oe = rst_oe_q && i_int_reset_req; // RULE10
    end else begin
      o_shared_reset_pin    = i_gpio_out;
      o_shared_reset_pin_oe = i_gpio_oe;
    end
  end

  assign o_pin_reset = rst_en_q && !pin_s2_q; // RULE10
  assign o_gpio_in   = pin_s2_q;

  // stabilization wait on wake even with an external clock
  logic osc_start;
  assign osc_start = (i_wake_stop || i_wake_sub)
                     && (i_ext_clk_sel || !i_ext_clk_sel); // RULE11

  mmd_osc_wait u_osc_wait (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_start   (osc_start),
    .o_busy    (o_osc_wait)
  );

  // checks run on the system clock and rest while reset is held
  default clocking chk_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  // region select follows the access by one cycle
  one_sel_a: assert property ( // RULE13
    $past(i_req.valid) |-> $onehot(sel_q))
    else $error("region select not one hot");
  idle_sel_a: assert property ( // RULE13
    !$past(i_req.valid) |-> sel_q == '0)
    else $error("select without access");
  rd_zero_a: assert property ( // RULE13
    i_req.valid && !i_req.write |=> o_rd_zero == sel_q.none)
    else $error("unmapped read not flagged");
  unmap_wr_a: assert property ( // RULE13
    sel_q.none |-> !we_q)
    else $error("write to unmapped area");

  // plain accesses land in their areas
  io_sel_a: assert property ( // RULE2
    i_req.valid && !i_req.direct && !i_req.gpr_mode
    && i_req.addr <= IO_HI |=> sel_q.io)
    else $error("io area not selected");
  xio_sel_a: assert property ( // RULE3
    i_req.valid && !i_req.direct && !i_req.gpr_mode
    && i_req.addr >= XIO_LO && i_req.addr <= XIO_HI |=> sel_q.xio)
    else $error("extended io not selected");
  ram_top_a: assert property ( // RULE6
    i_req.valid && !i_req.direct && !i_req.gpr_mode
    && i_req.addr > RAM_HI_SML && i_req.addr <= RAM_HI_BIG
    |=> (SMALL_RAM ? sel_q.none : sel_q.ram))
    else $error("ram top of variant wrong");
  vec_sel_a: assert property ( // RULE8
    i_req.valid && !i_req.direct && !i_req.gpr_mode
    && i_req.addr >= VEC_LO |=> sel_q.vec && !we_q)
    else $error("vector area decode wrong");
  nvr_sel_a: assert property ( // RULE9
    i_req.valid && !i_req.direct && !i_req.gpr_mode
    && i_req.addr >= NVR_LO && i_req.addr <= NVR_HI |=> sel_q.nonvolatile_register)
    else $error("nvr area not selected");

  // direct and register-window translation
  dir_low_a: assert property ( // RULE12
    i_req.valid && i_req.direct && !i_req.gpr_mode
    && i_req.addr[7] == 1'b0 |=> pa_q == {8'h00, $past(i_req.addr[7:0])})
    else $error("low direct operand remapped");
  bank_map_a: assert property ( // RULE5
    i_req.valid && i_req.direct && !i_req.gpr_mode && i_req.addr[7]
    && dbp_q != 3'h0 |=> pa_q[15:7] == 9'($past(dbp_q)) + 9'h001)
    else $error("bank mapping wrong");
  gpr_map_a: assert property ( // RULE7
    i_req.valid && i_req.gpr_mode |=> sel_q.gpr && pa_q[15:8] == 8'h01
    && pa_q[7:5] == $past(i_gpr_bank)
    && pa_q[4:0] == $past(i_req.addr[4:0]))
    else $error("register window mapping wrong");

  // vector entries, pin control and wake wait
  vec_addr_a: assert property ( // RULE8
    i_vector_call_instruction || i_vec_irq
    |=> o_vec_addr >= VEC_LO && o_vec_addr[0] == 1'b0)
    else $error("vector entry outside table");
  pin_ctl_a: assert property ( // RULE10
    rst_en_q |-> !o_shared_reset_pin && (rst_oe_q || !o_shared_reset_pin_oe))
    else $error("reset pin driven against its control bits");
  wake_wait_a: assert property ( // RULE11
    i_wake_stop || i_wake_sub |=> o_osc_wait [*8])
    else $error("no stabilization wait on wake");

endmodule : mmd_decoder

// ---- tb/mmd_cpu_model.sv ----
// cpu core model that issues accesses to the decoder
module mmd_cpu_model
  import mmd_pkg::*;
(
  // request to the decoder
  output mmd_req_type o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_req = '0;

  // one request, held until the next call
  task automatic put(input logic w, d, g, input logic [15:0] a,
                     input logic [7:0] wd);
    o_req <= '{1'b1, w, d, g, a, wd};
  endtask : put

  // release; address flipped so a stale value is never mistaken
  task automatic idle();
    o_req <= '{1'b0, 1'b0, 1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
  endtask : idle
endmodule : mmd_cpu_model

// ---- tb/tb_mmd_decoder.sv ----
// self-checking bench for the memory map address decoder
module tb_mmd_decoder import mmd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys, i_reset, i_dbp_we, i_vector_call_instruction, i_vec_irq;
  logic i_cfg_we, i_reset_output_enable_bit, i_reset_pin_function_select;
  logic i_int_reset_req, i_gpio_out, i_gpio_oe, i_ext_clk_sel, ext_low;
  logic i_wake_stop, i_wake_sub, o_wr_en, o_rd_zero, o_osc_wait;
  logic o_shared_reset_pin, o_shared_reset_pin_oe, o_pin_reset, o_gpio_in;
  logic [2:0]  i_gpr_bank, i_dbp_wdata, o_direct_bank_pointer;
  logic [4:0]  i_vec_num;
  logic [15:0] o_phys_addr, o_vec_addr;
  mmd_sel_type o_sel, sel2;
  mmd_req_type i_req;
  wire logic   i_shared_reset_pin;
  int          mismatches = 0, comparisons = 0, cyc = 0;
  logic [31:0] seed;
  logic [15:0] tab [22] = '{16'h0000, 16'h007F, 16'h0080, 16'h008F,
    16'h0090, 16'h00FF, 16'h0100, 16'h01FF, 16'h0200, 16'h028F, 16'h0290,
    16'h047F, 16'h0480, 16'h0F7F, 16'h0F80, 16'h0FFF, 16'h1000, 16'hFFBA,
    16'hFFBB, 16'hFFBF, 16'hFFC0, 16'hFFFF};
  logic [7:0]  dl [5] = '{8'h00, 8'h7F, 8'h80, 8'h8F, 8'hFF};

  // pin level: pulled up, low when anyone drives it low
  assign i_shared_reset_pin =
    ~((o_shared_reset_pin_oe & ~o_shared_reset_pin) | ext_low);

  mmd_cpu_model cpu (.o_req(i_req));
  mmd_decoder dut (.*);
  mmd_decoder #(.SMALL_RAM(1'b1)) dut2 (.*, .o_sel(sel2), .o_phys_addr(),
    .o_wr_en(), .o_rd_zero(), .o_direct_bank_pointer(), .o_vec_addr(),
    .o_shared_reset_pin(), .o_shared_reset_pin_oe(), .o_pin_reset(),
    .o_gpio_in(), .o_osc_wait());

  // 40 MHz clock
  initial i_clk_sys = 1'b0;
  always #12.5 i_clk_sys = ~i_clk_sys;

  // hang guard
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      final_report();
    end
  end

  // expected region of a physical address
  function automatic mmd_sel_type sel_f(input logic [15:0] a, input bit sm);
    mmd_sel_type s;
    s = '0;
    if (a <= 16'h007F) s.io = 1'b1;
    else if (a >= 16'h0F80 && a <= 16'h0FFF) s.xio = 1'b1;
    else if (a >= 16'h0100 && a <= 16'h01FF) s.gpr = 1'b1;
    else if (a >= 16'h0090 && a <= (sm ? 16'h028F : 16'h047F)) s.ram = 1'b1;
    else if (a >= 16'hFFC0) s.vec = 1'b1;
    else if (a >= 16'hFFBB) s.nonvolatile_register = 1'b1;
    else if (a >= 16'h1000) s.flash = 1'b1;
    else s.none = 1'b1;
    return s;
  endfunction : sel_f

  // expected target of a direct operand under a bank pointer
  function automatic logic [15:0] dir_f(input logic [7:0] a,
                                        input logic [2:0] b);
    if (a < 8'h80 || b == 3'h0) return {8'h00, a};
    return 16'h0080 + {6'h00, b, 7'h00} + {9'h000, a[6:0]};
  endfunction : dir_f

  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // compare and count
  task automatic chk(input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  // one access, answer looked at one cycle later
  task automatic acc(input logic w, d, g, input logic [15:0] a, pa);
    mmd_sel_type s;
    s = sel_f(pa, 1'b0);
    cpu.put(w, d, g, a, a[15:8] ^ a[7:0]);
    @(negedge i_clk_sys);
    chk(16'(o_sel), 16'(s));
    chk(16'(sel2), 16'(sel_f(pa, 1'b1)));
    chk(o_phys_addr, pa);
    chk(16'(o_wr_en), 16'(w & (s.io | s.xio | s.ram | s.gpr)));
    chk(16'(o_rd_zero), 16'(!w & s.none));
  endtask : acc

  // verdict and end of run
  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // main sequence, inputs change at falling edges
  initial begin
    seed = 32'd79753;
    {i_reset, i_ext_clk_sel} = 2'b11;
    {i_reset_output_enable_bit, i_reset_pin_function_select} = 2'b11;
    {i_dbp_we, i_vector_call_instruction, i_vec_irq, i_cfg_we} = 4'h0;
    {i_int_reset_req, i_gpio_out, i_gpio_oe, ext_low} = 4'h0;
    {i_wake_stop, i_wake_sub, i_gpr_bank, i_dbp_wdata, i_vec_num} = '0;
    repeat (6) @(negedge i_clk_sys);
    chk(16'(o_sel), 16'h0000);
    chk(16'(o_direct_bank_pointer), 16'h0000);
    chk(o_vec_addr, 16'hFFFE);
    i_reset = 1'b0;
    @(negedge i_clk_sys);
    chk(16'(o_osc_wait), 16'h0001);
    foreach (tab[i]) begin
      acc(i[0], 1'b0, 1'b0, tab[i], tab[i]);
    end
    repeat (200) begin
      seed = lfsr(seed);
      acc(seed[16], 1'b0, 1'b0, seed[15:0], seed[15:0]);
    end
    for (int b = 0; b < 8; b++) begin
      cpu.idle();
      i_dbp_we = 1'b1;
      i_dbp_wdata = 3'(b);
      @(negedge i_clk_sys);
      i_dbp_we = 1'b0;
      chk(16'(o_direct_bank_pointer), 16'(b));
      seed = lfsr(seed);
      foreach (dl[k]) begin
        acc(seed[k], 1'b1, 1'b0, {8'h00, dl[k]},
            dir_f(dl[k], 3'(b)));
      end
    end
    for (int b = 0; b < 8; b++) begin
      seed = lfsr(seed);
      i_gpr_bank = 3'(b);
      acc(seed[5], 1'b0, 1'b1, {11'h000, seed[4:0]},
          {8'h01, 3'(b), seed[4:0]});
    end
    cpu.idle();
    for (int n = 0; n < 32; n++) begin
      {i_vector_call_instruction, i_vec_irq, i_vec_num} = {n[0], !n[0], 5'(n)};
      @(negedge i_clk_sys);
      {i_vector_call_instruction, i_vec_irq} = 2'b00;
      chk(o_vec_addr, 16'hFFFF - 16'(2 * n + 1));
      @(negedge i_clk_sys);
    end
    chk(16'(o_osc_wait), 16'h0000);
    for (int w = 0; w < 2; w++) begin
      {i_wake_stop, i_wake_sub} = w[0] ? 2'b01 : 2'b10;
      i_ext_clk_sel = w[0]; // wait must not depend on the clock source
      @(negedge i_clk_sys);
      {i_wake_stop, i_wake_sub} = 2'b00;
      chk(16'(o_osc_wait), 16'h0001);
      repeat (250) @(negedge i_clk_sys);
      chk(16'(o_osc_wait), 16'h0001);
      repeat (10) @(negedge i_clk_sys);
      chk(16'(o_osc_wait), 16'h0000);
    end
    // reset mode: internal request pulls the pin, then an outside low
    i_int_reset_req = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk(16'({o_shared_reset_pin_oe, o_shared_reset_pin, o_pin_reset}),
        16'h0005);
    {i_int_reset_req, ext_low} = 2'b01;
    repeat (3) @(negedge i_clk_sys);
    chk(16'({o_shared_reset_pin_oe, o_pin_reset}), 16'h0001);
    // reset output disabled: a request leaves the pin released
    {ext_low, i_cfg_we, i_reset_output_enable_bit} = 3'b010;
    @(negedge i_clk_sys);
    {i_cfg_we, i_int_reset_req} = 2'b01;
    repeat (3) @(negedge i_clk_sys);
    chk(16'({o_shared_reset_pin_oe, o_pin_reset}), 16'h0000);
    // general-purpose mode
    {i_int_reset_req, i_cfg_we, i_reset_pin_function_select} = 3'b010;
    i_gpio_oe = 1'b1;
    @(negedge i_clk_sys);
    i_cfg_we = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    chk(16'({o_shared_reset_pin_oe, o_shared_reset_pin, o_pin_reset,
             o_gpio_in}), 16'h0008);
    i_gpio_out = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk(16'({o_shared_reset_pin_oe, o_shared_reset_pin, o_pin_reset,
             o_gpio_in}), 16'h000D);
    // mid-run reset: pointer, pin and wait return to power-on state
    i_reset = 1'b1;
    @(negedge i_clk_sys);
    chk(16'(o_direct_bank_pointer), 16'h0000);
    chk(16'(o_shared_reset_pin_oe), 16'h0000);
    i_reset = 1'b0;
    @(negedge i_clk_sys);
    chk(16'(o_osc_wait), 16'h0001);
    final_report();
  end
endmodule : tb_mmd_decoder
